/* verilog/bit_test_skip_consts.svh */
// constants for the bit test and skip execution block
`ifndef BIT_TEST_SKIP_CONSTS_SVH
`define BIT_TEST_SKIP_CONSTS_SVH
`define BTS_OPC_NIBBLE 4'h9
`define BTS_OPC_MSB 15
`define BTS_OPC_LSB 12
`define BTS_POL_BIT 11
`define BTS_POL_WHEN_ZERO 1'h1
`define BTS_SEL_MSB 10
`define BTS_SEL_LSB 8
`define BTS_ADDR_MSB 7
`define BTS_PHASE_Q1 2'h0
`define BTS_PHASE_Q2 2'h1
`define BTS_PHASE_Q3 2'h2
`define BTS_PHASE_Q4 2'h3
`define BTS_PHASE_COUNT 4
`endif

/* verilog/bit_test_skip_pkg.sv */
// types for the bit test and skip execution block
package bit_test_skip_pkg;
  typedef enum logic [1:0] {
    EXEC_IDLE,
    EXEC_TEST,
    EXEC_FORCED_NOP
  } exec_type;

  typedef struct packed {
    exec_type st;
    logic when_one;
    logic [2:0] bit_sel;
    logic [7:0] mem_addr;
    logic mem_rd;
    logic discard;
    logic forced_nop;
    logic nop_pending;
    logic wr_inhibit;
  } state_type;
endpackage

/* verilog/q_phase_gen.sv */
// four phase generator dividing each instruction cycle
`include "bit_test_skip_consts.svh"
module q_phase_gen #(
  parameter int PHASES = `BTS_PHASE_COUNT
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // phase
  output logic [1:0] phase_o
);
  initial begin
    if (PHASES != 4) $error("q_phase_gen serves exactly four phases");
  end

  logic [1:0] phase_d;
  logic [1:0] phase_q;

  always_comb begin
    phase_d = phase_q + 2'h1;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= `BTS_PHASE_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;
endmodule

/* verilog/bit_test_skip_exec.sv */
// execution of the two bit test and skip instructions
`include "bit_test_skip_consts.svh"
// Summary of operation
// - skip next instruction when tested bit zero
// - skip next instruction when tested bit one
// - taken skip discards prefetch, costs two cycles
// - freed cycle runs forced nop, changes nothing
// - eight-bit address, three-bit bit index decoded
module bit_test_skip_exec #(
  parameter int DATA_W = 8,
  parameter int INSTR_W = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // prefetched instruction from fetch stage
  input wire logic [INSTR_W-1:0] instr_word_i,
  input wire logic instr_valid_i,
  // data memory read path
  output logic mem_rd_o,
  output logic [7:0] mem_addr_o,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  // fetch pipeline control
  output logic discard_o,
  output logic forced_nop_o,
  output logic wr_inhibit_o,
  output logic [1:0] phase_o
);
  initial begin
    if (DATA_W != 8) $error("data width must be 8");
    if (INSTR_W != 16) $error("instruction width must be 16");
  end

  // ************************************************
  // phase sequencing
  // ************************************************
  logic [1:0] phase;

  q_phase_gen #(
    .PHASES(`BTS_PHASE_COUNT)
  ) u_phase (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .phase_o(phase)
  );

  // ************************************************
  // instruction cycle state
  // ************************************************
  bit_test_skip_pkg::state_type s_q;
  bit_test_skip_pkg::state_type s_d;
  logic is_test;
  logic tested_bit;

  // opcode match ignores the polarity bit; both forms share the nibble
  assign is_test = instr_valid_i &&
    (instr_word_i[`BTS_OPC_MSB:`BTS_OPC_LSB] == `BTS_OPC_NIBBLE);
  assign tested_bit = mem_rdata_i[s_q.bit_sel];

  always_comb begin
    s_d = s_q;
    s_d.mem_rd = 1'h0;
    s_d.discard = 1'h0;
    case (phase)
      `BTS_PHASE_Q1: begin
        // prefetched word is held off when a skip was taken
        if (s_q.nop_pending) begin
          s_d.st = bit_test_skip_pkg::EXEC_FORCED_NOP;
          s_d.forced_nop = 1'h1;
          s_d.wr_inhibit = 1'h1;
          s_d.nop_pending = 1'h0;
        end else if (is_test) begin
          s_d.st = bit_test_skip_pkg::EXEC_TEST;
          s_d.forced_nop = 1'h0;
          s_d.when_one = (instr_word_i[`BTS_POL_BIT] != `BTS_POL_WHEN_ZERO);
          s_d.bit_sel = instr_word_i[`BTS_SEL_MSB:`BTS_SEL_LSB];
          s_d.mem_addr = instr_word_i[`BTS_ADDR_MSB:0];
          s_d.mem_rd = 1'h1;
          s_d.wr_inhibit = 1'h1;
        end else begin
          s_d.st = bit_test_skip_pkg::EXEC_IDLE;
          s_d.forced_nop = 1'h0;
          s_d.wr_inhibit = 1'h0;
        end
      end
      `BTS_PHASE_Q3: begin
        // data arrives one clock after the read strobe
        if (s_q.st == bit_test_skip_pkg::EXEC_TEST && tested_bit == s_q.when_one) begin
          s_d.discard = 1'h1;
          s_d.nop_pending = 1'h1;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  logic [1:0] phase_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= `BTS_PHASE_Q4;
    end else begin
      phase_q <= phase;
    end
  end

  assign mem_rd_o = s_q.mem_rd;
  assign mem_addr_o = s_q.mem_addr;
  assign discard_o = s_q.discard;
  assign forced_nop_o = s_q.forced_nop;
  assign wr_inhibit_o = s_q.wr_inhibit;
  assign phase_o = phase_q;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_skip_on_zero: assert property (
    (s_q.st == bit_test_skip_pkg::EXEC_TEST && phase == `BTS_PHASE_Q3 && !s_q.when_one && !tested_bit)
    |=> discard_o) else $error("zero bit did not skip");
  a_skip_on_one: assert property (
    (s_q.st == bit_test_skip_pkg::EXEC_TEST && phase == `BTS_PHASE_Q3 && s_q.when_one && tested_bit)
    |=> discard_o) else $error("one bit did not skip");
  a_no_false_skip: assert property (
    (s_q.st == bit_test_skip_pkg::EXEC_TEST && phase == `BTS_PHASE_Q3 && tested_bit != s_q.when_one)
    |=> !discard_o ##1 !forced_nop_o[*4]) else $error("skip taken on false condition");
  a_nop_follows: assert property (
    discard_o |-> ##2 forced_nop_o[*4] ##1 !forced_nop_o) else $error("forced nop cycle not four phases");
  a_nop_quiet: assert property (
    forced_nop_o |-> !mem_rd_o && !discard_o && wr_inhibit_o) else $error("forced nop was active");
  a_addr_decode: assert property (
    $rose(mem_rd_o) |-> mem_addr_o == $past(instr_word_i[7:0]) && phase_o == `BTS_PHASE_Q1)
    else $error("address not taken from operand");
  a_no_write: assert property (
    mem_rd_o |-> wr_inhibit_o [*4]) else $error("write not held off in test cycle");

  // ************************************************
  // pulse widths and phase placement
  // ************************************************
  // strobes are single clock pulses; a stretched one would read or discard twice
  a_rd_pulse: assert property (
    mem_rd_o |=> !mem_rd_o)
    else $error("read strobe longer than one clock");

  a_discard_pulse: assert property (
    discard_o |=> !discard_o)
    else $error("discard longer than one clock");

  a_rd_phase: assert property (
    mem_rd_o |-> phase_o == `BTS_PHASE_Q1)
    else $error("read strobe outside the read phase");

  a_discard_phase: assert property (
    discard_o |-> phase_o == `BTS_PHASE_Q3)
    else $error("discard outside the execute phase");

  a_phase_wrap: assert property (
    phase_o == `BTS_PHASE_Q4 |=> phase_o == `BTS_PHASE_Q1)
    else $error("phase did not wrap to the decode phase");

  // ************************************************
  // forced nop and write hold-off
  // ************************************************
  // a forced nop only ever follows a discard two clocks earlier
  a_nop_start: assert property (
    $rose(forced_nop_o) |-> phase_o == `BTS_PHASE_Q1 && $past(discard_o, 2))
    else $error("forced nop without a preceding discard");

  a_inhibit_span: assert property (
    $rose(forced_nop_o) |-> wr_inhibit_o && $past(wr_inhibit_o))
    else $error("write hold-off gap between test and forced nop");

  a_idle_quiet: assert property (
    !wr_inhibit_o |-> !forced_nop_o && !mem_rd_o && !discard_o)
    else $error("activity outside a held-off cycle");

  a_discard_held: assert property (
    discard_o |-> wr_inhibit_o && !forced_nop_o)
    else $error("discard outside a test cycle");

  // the address must not move while the memory answers
  a_addr_stable: assert property (
    mem_rd_o |=> $stable(mem_addr_o) [*3])
    else $error("address moved during the test cycle");

  c_skip_zero: cover property (discard_o && !s_q.when_one);
  c_skip_one: cover property (discard_o && s_q.when_one);
  c_no_skip: cover property (mem_rd_o ##3 !discard_o ##1 !forced_nop_o);
  c_test_after_nop: cover property (forced_nop_o ##4 mem_rd_o);
  c_idle_then_test: cover property (!wr_inhibit_o ##4 mem_rd_o);
endmodule

/* tb/mem_model.sv */
// data memory model answering the read strobe of the test block
module mem_model (
  // clock
  input wire logic sys_clk_i,
  // read path
  input wire logic mem_rd_i,
  input wire logic [7:0] mem_addr_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hold_q = 2'h0;
  initial mem_rdata_o = 8'h00;
  // contents are addr xor 5a; data holds two cycles, then flips so a late sample shows
  always @(posedge sys_clk_i) begin
    hold_q <= mem_rd_i ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
    mem_rdata_o <= mem_rd_i ? (mem_addr_i ^ 8'h5a) : (hold_q > 2'h1 ? mem_rdata_o : ~mem_rdata_o);
  end
endmodule

/* tb/bit_test_skip_exec_tb.sv */
// self-checking bench for the bit test and skip block
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module bit_test_skip_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_word_i = 16'h0000;
  logic [7:0] mem_rdata_i;
  logic [7:0] mem_addr_o;
  logic mem_rd_o, discard_o, forced_nop_o, wr_inhibit_o;
  logic [1:0] phase_o;
  logic [8:0] notes[$];
  int error_cnt = 0;
  int n_compared = 0;
  logic [8:0] exp_note;
  bit_test_skip_exec u_bit_test_skip_exec (.sys_clk_i, .rstn_i, .instr_word_i, .instr_valid_i, .mem_rd_o,
    .mem_addr_o, .mem_rdata_i, .discard_o, .forced_nop_o, .wr_inhibit_o, .phase_o);
  mem_model u_mem_model (.sys_clk_i, .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // drive one word so it stands at the decode edge
  task automatic issue(input logic v, input logic [15:0] w);
    do @(negedge sys_clk_i); while (phase_o !== 2'h2);
    @(posedge sys_clk_i);
    instr_valid_i <= v;
    instr_word_i <= w;
  endtask
  initial begin
    logic [15:0] w;
    logic [7:0] d;
    logic v, sk, tk;
    void'($urandom(32'hd1b1));
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    sk = 1'b0;
    for (int i = 0; i < 60; i++) begin
      w = 16'($urandom);
      w[15:12] = (i % 7 == 3) ? 4'h8 : 4'h9;
      if (i < 16) w[11:8] = i[3:0];
      v = (i % 11 != 5);
      d = w[7:0] ^ 8'h5a;
      tk = v && w[15:12] == 4'h9 && !sk;
      // word after a taken skip lands on the forced nop and is dropped
      if (tk) notes.push_back({w[7:0], w[11] ? !d[w[10:8]] : d[w[10:8]]});
      sk = tk && notes[$][0];
      issue(v, w);
    end
    issue(1'b0, 16'h0000);
    repeat (16) @(posedge sys_clk_i);
    `CHK("left", 0, notes.size())
    test_done();
  end
  // outputs of each test cycle are matched against the oldest note
  always @(posedge sys_clk_i) begin
    if (rstn_i && wr_inhibit_o === 1'b1 && forced_nop_o === 1'b0) begin
      if (phase_o === 2'h0) `CHK("rd", 1'b1, mem_rd_o)
      if (phase_o === 2'h2) begin
        `CHK("note", 1'b1, notes.size() > 0)
        if (notes.size() > 0) begin
          exp_note = notes.pop_front();
          `CHK("addr_skip", exp_note, {mem_addr_o, discard_o})
        end
      end
    end
    if (rstn_i && forced_nop_o === 1'b1) `CHK("nop_quiet", 2'h0, {mem_rd_o, discard_o})
    if (rstn_i && discard_o === 1'b1) `CHK("disc_phase", 2'h2, phase_o)
    if (rstn_i && forced_nop_o === 1'b1) `CHK("inhibit", 1'b1, wr_inhibit_o)
    if (rstn_i && wr_inhibit_o === 1'b0) `CHK("quiet", 2'h0, {mem_rd_o, discard_o})
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule
